// ### rtl/lapb_params.svh
// Constants for the link layer block: offsets, field positions, resets, timing.
// Assumes a 20 MHz system clock and a plain single-cycle register port.
// Functional notes
// - After the line drops the block waits the programmable modem-signal time (1000 to 10000 ms, 10 ms steps) before declaring the line down.
// - When supplying line timing the block drives its transmit clock at the chosen speed of 4800, 9600 or 19200 bps.
// - When the modem supplies timing the block works with any external line rate from 140 to 19200 bps.
// - The physical role is fixed as the terminal side of an X.21bis interface and cannot be selected.
// - Both stations run the balanced link access procedure for frame exchange.
// - Information frame sequence numbers count modulo 8 from 0 to 7 and wrap.
// - No more unacknowledged information frames are outstanding than window K, from 1 to 7, with 7 recommended.
// - Recovery starts when a sent frame is not acknowledged within T1, programmable from 1000 to 30000 ms in 10 ms steps.
// - A frame is sent at most 20 times in total including the first, a fixed limit; any accepted ack restarts the count, even one acknowledging no new frame.
// - The link role is terminal side unless the network type is the link-responder option, which makes it network side.
// - The maximum information frame length is fixed at 1048 bits, which is 131 bytes.
// - The configuration listing reports the maximum frame length in bytes.
// - Fast select is not supported, so accepted incoming calls stay within the maximum frame length.
// - The network type carries a count of called-address digits used to interpret incoming called addresses; the block only stores the count and never reads it.
// - A two-digit sub-address selects the port, and the no-sub-address type is used when the network lacks it; the block selects no port.
`ifndef LAPB_PARAMS_SVH
`define LAPB_PARAMS_SVH

`define LAPB_ADDR_CTRL 4'h0
`define LAPB_ADDR_MODEM_TMR 4'h1
`define LAPB_ADDR_T1 4'h2
`define LAPB_ADDR_STATUS 4'h3
`define LAPB_ADDR_IRQ_STAT 4'h4
`define LAPB_ADDR_IRQ_MASK 4'h5
`define LAPB_ADDR_CONFIG_LIST 4'h6
`define LAPB_ADDR_SEQ 4'h7

`define LAPB_CLK_HZ 20000000
`define LAPB_TICK_MS 10
`define LAPB_TICK_CYCLES ((`LAPB_CLK_HZ / 1000) * `LAPB_TICK_MS)
`define LAPB_MODEM_TMR_MIN 100
`define LAPB_MODEM_TMR_MAX 1000
`define LAPB_MODEM_TMR_RST 16'h0064
`define LAPB_T1_MIN 100
`define LAPB_T1_MAX 3000
`define LAPB_T1_RST 16'h012C
`define LAPB_N2 20
`define LAPB_N1_BITS 1048
`define LAPB_N1_BYTES 131
`define LAPB_K_RST 3'h7
`define LAPB_BAUD_4800 4800
`define LAPB_BAUD_9600 9600
`define LAPB_BAUD_19200 19200
`define LAPB_LINE_MIN_BPS 140
`define LAPB_LINE_MAX_BPS 19200

`define LAPB_CTRL_K_LSB 0
`define LAPB_CTRL_SPEED_LSB 3
`define LAPB_CTRL_INTCLK_BIT 5
`define LAPB_CTRL_NETTYPE_LSB 6
`define LAPB_CTRL_DIGITS_LSB 8
`define LAPB_CTRL_SUBADDR_LSB 12
`define LAPB_CTRL_RST 32'h0000_0007

`define LAPB_IRQ_LINE_DOWN 0
`define LAPB_IRQ_T1_EXPIRE 1
`define LAPB_IRQ_LINK_FAIL 2
`define LAPB_IRQ_ACKED 3

`endif

// ### rtl/lapb_pkg.sv
// Types shared by the link layer modules.
// Assumes lapb_params.svh supplies the numeric constants.
package lapb_pkg;
    typedef enum logic [1:0] {
        LAPB_NT_GENERIC_TERMINAL,
        LAPB_NT_NO_SUBADDRESS,
        LAPB_NT_LINK_RESPONDER,
        LAPB_NT_RESERVED
    } lapb_nettype_t;

    typedef enum logic [1:0] {
        LAPB_SPD_4800,
        LAPB_SPD_9600,
        LAPB_SPD_19200,
        LAPB_SPD_RSVD
    } lapb_speed_t;

    typedef enum {
        LAPB_LINK_DOWN,
        LAPB_LINK_SETUP,
        LAPB_LINK_UP,
        LAPB_LINK_RECOVER
    } lapb_link_t;
endpackage : lapb_pkg

// ### rtl/lapb_clk_gen.sv
// Internal transmit clock generator for the line.
// Assumes a 20 MHz system clock; output toggles from a register.
`timescale 1ns/10ps
`default_nettype none
`include "lapb_params.svh"

module lapb_clk_gen
    import lapb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire lapb_pkg::lapb_speed_t i_speed,
    output logic o_line_clk
);
    typedef struct packed {
        logic [11:0] cnt;
        logic clk;
    } lapb_cg_state_t;

    lapb_cg_state_t s_reg;
    lapb_cg_state_t s_next;
    logic [11:0] half;

    // Half period count in system cycles for each chosen speed.
    always_comb
    begin
        case (i_speed)
            LAPB_SPD_9600: half = 12'((`LAPB_CLK_HZ / (2 * `LAPB_BAUD_9600)) - 1);
            LAPB_SPD_19200: half = 12'((`LAPB_CLK_HZ / (2 * `LAPB_BAUD_19200)) - 1);
            default: half = 12'((`LAPB_CLK_HZ / (2 * `LAPB_BAUD_4800)) - 1);
        endcase
    end

    // Divider that toggles the line clock at each half period.
    always_comb
    begin
        s_next = s_reg;
        if (s_reg.cnt >= half)
        begin
            s_next.cnt = 12'h000;
            s_next.clk = ~s_reg.clk;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 12'h001;
        end
    end

    // State register.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign o_line_clk = s_reg.clk;

    // The divider count never passes 2083, whatever speed is chosen.
    a_half_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.cnt <= 12'd2083))
        else $error("line clock divider ran past its half period");
endmodule : lapb_clk_gen
`default_nettype wire

// ### rtl/lapb_link.sv
// Link layer top: line monitor, clock choice, I-frame sequencing, T1 and N2.
// Assumes a single-cycle register port and modem pins from outside the clock domain.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "lapb_params.svh"

module lapb_link
    import lapb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_carrier,
    input wire logic i_modem_clk,
    input wire logic i_tx_req,
    input wire logic i_ack_valid,
    input wire logic [2:0] i_ack_nr,
    input wire logic i_link_est,
    output logic o_tx_send,
    output logic [2:0] o_tx_ns,
    output logic o_tx_ready,
    output logic o_line_clk,
    output logic o_line_up,
    output logic o_role_network,
    output logic o_link_fail,
    output logic o_irq
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] modem_tmr;
        logic [15:0] t1;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [31:0] rdata;
        logic [1:0] car_sync;
        logic [2:0] mclk_sync;
        logic [18:0] tick_cnt;
        logic [15:0] drop_cnt;
        logic line_up;
        logic [2:0] vs;
        logic [2:0] va;
        logic [15:0] t1_cnt;
        logic t1_run;
        logic [4:0] tries;
        logic send;
        logic [2:0] ns;
        logic ready;
        logic fail;
        logic irq;
        logic [15:0] edge_cnt;
        lapb_link_t link;
    } lapb_state_t;

    lapb_state_t s_reg;
    lapb_state_t s_next;
    logic int_clk;
    logic tick;
    logic [2:0] outstanding;
    logic [3:0] events;

    // Number of frames sent and not yet acknowledged, modulo 8.
    function automatic logic [2:0] seq_dist(input logic [2:0] a, input logic [2:0] b);
        seq_dist = a - b;
    endfunction : seq_dist

    // Internal line clock used when the block supplies timing.
    lapb_clk_gen u_clk_gen (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_speed(lapb_speed_t'(s_reg.ctrl[`LAPB_CTRL_SPEED_LSB +: 2])),
        .o_line_clk(int_clk)
    );

    assign tick = (s_reg.tick_cnt == 19'(`LAPB_TICK_CYCLES - 1));
    assign outstanding = seq_dist(s_reg.vs, s_reg.va);

    // Main next-state logic.
    always_comb
    begin
        s_next = s_reg;
        events = 4'h0;
        s_next.send = 1'b0;
        s_next.fail = 1'b0;
        s_next.rdata = 32'h0000_0000;

        // Synchronisers for the modem pins; carrier is read at the second stage, the modem clock at the second and third.
        s_next.car_sync = {s_reg.car_sync[0], i_carrier};
        s_next.mclk_sync = {s_reg.mclk_sync[1:0], i_modem_clk};

        // Ten millisecond time base.
        s_next.tick_cnt = tick ? 19'h00000 : s_reg.tick_cnt + 19'h00001;

        // Line drop supervision: declare down after the modem-signal time.
        if (s_reg.car_sync[1])
        begin
            s_next.drop_cnt = 16'h0000;
            s_next.line_up = 1'b1;
        end
        else if (s_reg.line_up && tick)
        begin
            if (s_reg.drop_cnt + 16'h0001 >= s_reg.modem_tmr)
            begin
                s_next.line_up = 1'b0;
                events[`LAPB_IRQ_LINE_DOWN] = 1'b1;
            end
            s_next.drop_cnt = s_reg.drop_cnt + 16'h0001;
        end

        // Modem clock edges are only counted; any rate in range is accepted.
        if (s_reg.mclk_sync[2:1] == 2'b01)
            s_next.edge_cnt = s_reg.edge_cnt + 16'h0001;

        // Link state: establishment, data transfer and failure recovery.
        case (s_reg.link)
            LAPB_LINK_DOWN:
                if (s_reg.line_up)
                    s_next.link = LAPB_LINK_SETUP;
            LAPB_LINK_SETUP:
                if (i_link_est)
                begin
                    s_next.link = LAPB_LINK_UP;
                    s_next.vs = 3'h0;
                    s_next.va = 3'h0;
                    s_next.tries = 5'h00;
                    s_next.t1_run = 1'b0;
                end
            LAPB_LINK_UP:
            begin
                if (i_ack_valid && seq_dist(i_ack_nr, s_reg.va) <= outstanding)
                begin
                    s_next.va = i_ack_nr;
                    s_next.tries = (i_ack_nr != s_reg.vs) ? 5'h01 : 5'h00;
                    s_next.t1_cnt = 16'h0000;
                    s_next.t1_run = (i_ack_nr != s_reg.vs);
                    if (i_ack_nr != s_reg.va)
                        events[`LAPB_IRQ_ACKED] = 1'b1;
                end
                if (i_tx_req && outstanding < s_reg.ctrl[`LAPB_CTRL_K_LSB +: 3])
                begin
                    s_next.send = 1'b1;
                    s_next.ns = s_reg.vs;
                    s_next.vs = s_reg.vs + 3'h1;
                    if (!s_next.t1_run)
                    begin
                        s_next.t1_run = 1'b1;
                        s_next.t1_cnt = 16'h0000;
                        s_next.tries = 5'h01;
                    end
                end
                if (s_reg.t1_run && tick && !i_ack_valid)
                begin
                    if (s_reg.t1_cnt + 16'h0001 >= s_reg.t1)
                    begin
                        events[`LAPB_IRQ_T1_EXPIRE] = 1'b1;
                        s_next.t1_cnt = 16'h0000;
                        if (s_reg.tries >= 5'(`LAPB_N2))
                        begin
                            s_next.fail = 1'b1;
                            events[`LAPB_IRQ_LINK_FAIL] = 1'b1;
                            s_next.link = LAPB_LINK_RECOVER;
                            s_next.t1_run = 1'b0;
                        end
                        else
                        begin
                            s_next.tries = s_reg.tries + 5'h01;
                            s_next.send = 1'b1;
                            s_next.ns = s_reg.va;
                            s_next.vs = s_reg.va + 3'h1;
                        end
                    end
                    else
                        s_next.t1_cnt = s_reg.t1_cnt + 16'h0001;
                end
            end
            LAPB_LINK_RECOVER:
            begin
                s_next.fail = 1'b0;
                s_next.link = LAPB_LINK_SETUP;
            end
            default:
                s_next.link = LAPB_LINK_DOWN;
        endcase
        if (!s_reg.line_up && s_reg.link != LAPB_LINK_DOWN)
        begin
            s_next.link = LAPB_LINK_DOWN;
            s_next.t1_run = 1'b0;
        end
        // Ready mirrors the next link state so the output comes from a flip-flop.
        s_next.ready = (s_next.link == LAPB_LINK_UP);

        // Register writes; out-of-range timer values are clamped.
        if (i_wr)
        begin
            case (i_addr)
                `LAPB_ADDR_CTRL:
                begin
                    s_next.ctrl = i_wdata;
                    if (i_wdata[`LAPB_CTRL_K_LSB +: 3] == 3'h0)
                        s_next.ctrl[`LAPB_CTRL_K_LSB +: 3] = 3'h1;
                end
                `LAPB_ADDR_MODEM_TMR:
                    if (i_wdata[15:0] < 16'(`LAPB_MODEM_TMR_MIN))
                        s_next.modem_tmr = 16'(`LAPB_MODEM_TMR_MIN);
                    else if (i_wdata[15:0] > 16'(`LAPB_MODEM_TMR_MAX))
                        s_next.modem_tmr = 16'(`LAPB_MODEM_TMR_MAX);
                    else
                        s_next.modem_tmr = i_wdata[15:0];
                `LAPB_ADDR_T1:
                    if (i_wdata[15:0] < 16'(`LAPB_T1_MIN))
                        s_next.t1 = 16'(`LAPB_T1_MIN);
                    else if (i_wdata[15:0] > 16'(`LAPB_T1_MAX))
                        s_next.t1 = 16'(`LAPB_T1_MAX);
                    else
                        s_next.t1 = i_wdata[15:0];
                `LAPB_ADDR_IRQ_MASK:
                    s_next.irq_mask = i_wdata[3:0];
                default:
                    s_next.irq_mask = s_next.irq_mask;
            endcase
        end

        // Sticky status: write one clears, a new event in the same cycle wins.
        s_next.irq_stat = s_reg.irq_stat;
        if (i_wr && i_addr == `LAPB_ADDR_IRQ_STAT)
            s_next.irq_stat = s_reg.irq_stat & ~i_wdata[3:0];
        s_next.irq_stat = s_next.irq_stat | events;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

        // Register reads, answered in the next cycle.
        if (i_rd)
        begin
            case (i_addr)
                `LAPB_ADDR_CTRL: s_next.rdata = s_reg.ctrl;
                `LAPB_ADDR_MODEM_TMR: s_next.rdata = {16'h0000, s_reg.modem_tmr};
                `LAPB_ADDR_T1: s_next.rdata = {16'h0000, s_reg.t1};
                `LAPB_ADDR_STATUS:
                    s_next.rdata = {s_reg.edge_cnt, 3'h0, s_reg.tries, 1'b0, outstanding,
                        s_reg.va, s_reg.line_up};
                `LAPB_ADDR_IRQ_STAT: s_next.rdata = {28'h0000000, s_reg.irq_stat};
                `LAPB_ADDR_IRQ_MASK: s_next.rdata = {28'h0000000, s_reg.irq_mask};
                `LAPB_ADDR_CONFIG_LIST:
                    s_next.rdata = {16'h0000, 8'(`LAPB_N2), 8'(`LAPB_N1_BYTES)};
                `LAPB_ADDR_SEQ: s_next.rdata = {26'h0000000, s_reg.vs, s_reg.va};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_reg <= '0;
            s_reg.ctrl <= `LAPB_CTRL_RST;
            s_reg.modem_tmr <= `LAPB_MODEM_TMR_RST;
            s_reg.t1 <= `LAPB_T1_RST;
            s_reg.link <= LAPB_LINK_DOWN;
            o_line_clk <= 1'b0;
            o_role_network <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
            // Own clock when the internal clock is chosen, else follow the modem.
            o_line_clk <= s_reg.ctrl[`LAPB_CTRL_INTCLK_BIT] ? int_clk : s_reg.mclk_sync[1];
            // Physical side is always terminal; only the link role follows the type.
            o_role_network <= (s_reg.ctrl[`LAPB_CTRL_NETTYPE_LSB +: 2] == 2'(LAPB_NT_LINK_RESPONDER));
        end
    end

    // Output assignments straight from the state register.
    assign o_rdata = s_reg.rdata;
    assign o_tx_send = s_reg.send;
    assign o_tx_ns = s_reg.ns;
    assign o_tx_ready = s_reg.ready;
    assign o_line_up = s_reg.line_up;
    assign o_link_fail = s_reg.fail;
    assign o_irq = s_reg.irq;

    // Window is never exceeded.
    a_window_limit: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.link == LAPB_LINK_UP) |-> (outstanding <= s_reg.ctrl[2:0]))
        else $error("outstanding frames exceed window");

    // Send numbers step by one modulo eight on a fresh send.
    a_seq_step: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.send && !$past(s_reg.t1_run && s_reg.t1_cnt == 16'h0000 && s_reg.send))
        |-> (s_reg.vs == $past(s_reg.vs) + 3'h1 || s_reg.vs == $past(s_reg.va) + 3'h1))
        else $error("send sequence did not step modulo eight");

    // Tries never exceed the fixed limit.
    a_retry_cap: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.tries <= 5'd20)
        else $error("retry count passed twenty");

    // Link failure is in recovery in the same cycle, and the fail pulse ends in the next.
    a_fail_recover: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(s_reg.fail) |-> (s_reg.link == LAPB_LINK_RECOVER) ##1 !s_reg.fail)
        else $error("failed link did not start recovery");

    // Line stays up while carrier is present.
    a_line_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.car_sync[1] |=> s_reg.line_up)
        else $error("line declared down with carrier present");

    // T1 stays inside its programmable range; the modem-signal time stays at or above its minimum.
    a_timer_range: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_reg.t1 >= 16'd100) && (s_reg.t1 <= 16'd3000) && (s_reg.modem_tmr >= 16'd100))
        else $error("timer setting out of range");

    // Listing reports the frame length in bytes.
    a_list_bytes: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == 4'h6) |=> (o_rdata[7:0] == 8'd131))
        else $error("frame length not listed as bytes");

    // Network role follows the link-responder type.
    a_role_type: assert property (@(posedge i_clk) disable iff (i_rst)
        ##2 (o_role_network == ($past(s_reg.ctrl[7:6]) == 2'd2)))
        else $error("link role does not follow network type");

    // A frame sent or resent always lies inside the open window.
    a_ns_window: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.send |-> (seq_dist(s_reg.ns, s_reg.va) < seq_dist(s_reg.vs, s_reg.va)))
        else $error("sent frame number outside the window");

    // A running T1 always has at least one transmission on the count.
    a_tries_live: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.t1_run |-> (s_reg.tries != 5'd0))
        else $error("T1 running with no transmission counted");

    // T1 starts from zero with the first transmission counted.
    a_t1_start: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(s_reg.t1_run) |-> (s_reg.t1_cnt == 16'd0) && (s_reg.tries == 5'd1))
        else $error("T1 did not start fresh");
endmodule : lapb_link
`default_nettype wire

// ### dv/lapb_peer_model.sv
// Far-end link station model: acknowledges every I-frame the block sends.
// Assumes the block pulses i_send for one cycle with the frame's N(S) beside it.
`timescale 1ns/10ps
`default_nettype none

module lapb_peer_model
(
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic [2:0] i_ns,
    input wire logic [15:0] i_delay,
    output logic o_ack_valid,
    output logic [2:0] o_ack_nr
);
    int due_q[$];
    logic [2:0] nr_q[$];
    int now = 0;
    logic ack_v = 1'b0;
    logic [2:0] ack_n = 3'h0;

    // Outputs come from the model's own registers, quiet at start.
    assign o_ack_valid = ack_v;
    assign o_ack_nr = ack_n;

    // Each frame gets a cumulative acknowledgement after i_delay cycles.
    // Between pulses the number lines keep changing, so no stale value is held.
    always @(posedge i_clk)
    begin
        now <= now + 1;
        ack_v <= 1'b0;
        ack_n <= ~ack_n;
        if (due_q.size() > 0 && due_q[0] <= now)
        begin
            ack_v <= 1'b1;
            ack_n <= nr_q.pop_front();
            void'(due_q.pop_front());
        end
        if (i_send === 1'b1)
        begin
            due_q.push_back(now + int'(i_delay));
            nr_q.push_back(i_ns + 3'h1);
        end
    end
endmodule : lapb_peer_model

`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the link block: register port, window, sequencing, clocks.
// Assumes the peer model answers frames; timers of 10 ms ticks are too long to run here.
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic i_clk, i_rst, i_wr, i_rd, i_carrier, i_modem_clk, i_tx_req, i_link_est;
    logic i_ack_valid, o_tx_send, o_tx_ready, o_line_clk, o_line_up;
    logic o_role_network, o_link_fail, o_irq, line_q, ia, ib;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [2:0] i_ack_nr, o_tx_ns, exp_ns;
    logic [15:0] ack_delay;
    int miscompares = 0, checked = 0, cycles = 0, sends = 0, base;
    int per_cnt = 0, last_per = 0;
    int kv[3] = '{1, 2, 7};
    int lo[3] = '{4162, 2079, 1037};

    lapb_link dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_carrier(i_carrier),
        .i_modem_clk(i_modem_clk), .i_tx_req(i_tx_req), .i_ack_valid(i_ack_valid),
        .i_ack_nr(i_ack_nr), .i_link_est(i_link_est), .o_tx_send(o_tx_send),
        .o_tx_ns(o_tx_ns), .o_tx_ready(o_tx_ready), .o_line_clk(o_line_clk),
        .o_line_up(o_line_up), .o_role_network(o_role_network),
        .o_link_fail(o_link_fail), .o_irq(o_irq));

    lapb_peer_model peer_u (.i_clk(i_clk), .i_send(o_tx_send), .i_ns(o_tx_ns),
        .i_delay(ack_delay), .o_ack_valid(i_ack_valid), .o_ack_nr(i_ack_nr));

    // System clock of 50 ns and an unrelated 400 ns modem clock.
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial
    begin
        i_modem_clk = 1'b0;
        #13;
        forever #200 i_modem_clk = ~i_modem_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        rv = o_rdata;
    endtask : rd

    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask : rdc

    // Samples the interrupt line once a new mask has had time to land.
    task automatic irq_with(input logic [31:0] m, output logic v);
        wr(4'h5, m);
        @(posedge i_clk);
        @(negedge i_clk);
        v = o_irq;
        @(posedge i_clk);
    endtask : irq_with

    // Cuts a hang short and measures the line clock period in system cycles.
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            summarize();
        end
        line_q <= o_line_clk;
        if (o_line_clk === 1'b1 && line_q === 1'b0)
        begin
            last_per <= per_cnt;
            per_cnt <= 1;
        end
        else
            per_cnt <= per_cnt + 1;
    end

    // Every frame sent must carry the next number modulo 8.
    always @(negedge i_clk)
    begin
        if (o_tx_send === 1'b1)
        begin
            chk({29'h0, o_tx_ns}, {29'h0, exp_ns});
            exp_ns <= exp_ns + 3'h1;
            sends++;
        end
    end

    initial
    begin
        i_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_carrier = 1'b0;
        i_tx_req = 1'b0;
        i_link_est = 1'b0;
        ack_delay = 16'h0064;
        exp_ns = 3'h0;
        line_q = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rdc(4'h0, 32'h0000_0007);
        rdc(4'h1, 32'h0000_0064);
        rdc(4'h2, 32'h0000_012C);
        rdc(4'h6, 32'h0000_1483);
        chk(o_role_network, 1'b0);
        wr(4'h9, 32'hFFFF_FFFF);
        rdc(4'h9, 32'h0);
        wr(4'h1, 32'h0000_0032);
        rdc(4'h1, 32'h0000_0064);
        wr(4'h1, 32'h0000_07D0);
        rdc(4'h1, 32'h0000_03E8);
        wr(4'h2, 32'h0000_1388);
        rdc(4'h2, 32'h0000_0BB8);
        $display("Test registers done");
        for (int nt = 0; nt < 3; nt++)
        begin
            wr(4'h0, 32'h0000_0507 | (nt << 6));
            rdc(4'h0, 32'h0000_0507 | (nt << 6));
            chk(o_role_network, nt == 2);
        end
        wr(4'h0, 32'h0);
        rdc(4'h0, 32'h0000_0001);
        $display("Test role done");
        i_carrier <= 1'b1;
        for (int i = 0; i < 300 && o_line_up !== 1'b1; i++) @(posedge i_clk);
        chk(o_line_up, 1'b1);
        i_link_est <= 1'b1;
        for (int i = 0; i < 300 && o_tx_ready !== 1'b1; i++) @(posedge i_clk);
        i_link_est <= 1'b0;
        chk(o_tx_ready, 1'b1);
        foreach (kv[j])
        begin
            wr(4'h0, kv[j]);
            base = sends;
            i_tx_req <= 1'b1;
            repeat (60) @(posedge i_clk);
            chk(sends - base, kv[j]);
            i_tx_req <= 1'b0;
            repeat (200) @(posedge i_clk);
            rd(4'h3);
            chk(rv[6:4], 3'h0);
            chk(rv[31:16] != 16'h0000, 1'b1);
            chk(o_link_fail, 1'b0);
            rd(4'h7);
            chk({rv[5:3], rv[2:0]}, {exp_ns, exp_ns});
        end
        $display("Test window done");
        rd(4'h4);
        chk(rv[3], 1'b1);
        irq_with(32'h0, ia);
        irq_with(32'hF, ib);
        chk(ia, 1'b0);
        chk(ib, 1'b1);
        wr(4'h4, 32'hF);
        rd(4'h4);
        chk(rv[3:0], 4'h0);
        chk(o_irq, 1'b0);
        $display("Test interrupt done");
        for (int s = 0; s < 3; s++)
        begin
            wr(4'h0, 32'h0000_0027 | (s << 3));
            repeat (3 * (lo[s] + 9)) @(posedge i_clk);
            chk(last_per >= lo[s] && last_per <= lo[s] + 9, 1'b1);
        end
        wr(4'h0, 32'h0000_0007);
        repeat (60) @(posedge i_clk);
        chk(last_per >= 7 && last_per <= 9, 1'b1);
        $display("Test line clock done");
        summarize();
    end
endmodule : tb

`default_nettype wire
